/* File: core/zcd_control.sv */
// control, status and interrupt logic of the zero-cross detector
//
// Summary of operation
// - source, sink and interrupts keep running in sleep
// - fuse clear: detector active right after power-on
// - fuse set: inactive until software sets enable
// - fuse clear: enabled regardless of enable bit
// - module disable bit works only when fuse set
// - enable one: detector owns pin, sources/sinks
// - enable zero: pin released to normal routing
// - level bit shows sink one unless inverted
// - invert bit inverts detector logic output
// - rising edge sets flag when rise enabled
// - falling edge sets flag when fall enabled
// - bits 6,3,2 read zero, ignore writes
// - reset clears invert and edge enables
// - changing the invert bit sets the invert event status bit
// - edge during clear keeps the flag set
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module zcd_control
   import zcd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // configuration fuse and sleep
   input wire logic poweron_default_off_fuse,
   input wire logic sleep_mode,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   // analog stage
   input wire logic sink_active,
   output logic detector_active,
   output logic detector_logic_output,
   // interrupt
   output logic irq
);
   zcd_state_type state_reg, state_next;
   logic active;
   logic level;
   logic wr_ctl;
   logic invert_changed;
   logic rise_event;
   logic fall_event;

   // fuse clear forces the detector on; module disable only counts when fuse set
   always_comb begin
      active = !poweron_default_off_fuse
               || (state_reg.enable && !state_reg.module_disable);
   end

   always_comb begin
      state_next = state_reg;
      level = state_reg.sync2 ^ state_reg.invert;
      wr_ctl = wr_stb && (addr == ADDR_CONTROL);
      invert_changed = wr_ctl && (wdata[BIT_INVERT] != state_reg.invert);
      // edges count only once the fuse is seen and the detector is on
      rise_event = active && state_reg.fuse_seen && state_reg.rise_en
                   && level && !state_reg.out_prev;
      fall_event = active && state_reg.fuse_seen && state_reg.fall_en
                   && !level && state_reg.out_prev;

      // fuse sampled one cycle after reset release
      state_next.fuse_seen = 1'b1;
      if (!state_reg.fuse_seen) begin
         state_next.enable = !poweron_default_off_fuse;
      end

      // sleep does not gate the synchroniser or flag logic
      state_next.sync1 = sink_active;
      state_next.sync2 = state_reg.sync1;
      state_next.out_prev = level;

      if (wr_ctl) begin
         // only implemented bits are stored
         state_next.enable = wdata[BIT_ENABLE];
         state_next.invert = wdata[BIT_INVERT];
         state_next.rise_en = wdata[BIT_RISE];
         state_next.fall_en = wdata[BIT_FALL];
      end
      if (wr_stb && addr == ADDR_MASK) begin
         state_next.mask = wdata[1:0];
      end
      if (wr_stb && addr == ADDR_MODULE_DISABLE) begin
         state_next.module_disable = wdata[BIT_MD_DISABLE];
      end
      // write-one-to-clear first, then sets override it
      if (wr_stb && addr == ADDR_STATUS) begin
         state_next.status = state_reg.status & ~wdata[1:0];
      end
      // a set after the clear keeps an edge that meets a clear write
      if (rise_event) begin
         state_next.status[BIT_ST_CROSS] = 1'b1;
      end
      if (fall_event) begin
         state_next.status[BIT_ST_CROSS] = 1'b1;
      end
      if (invert_changed) begin
         state_next.status[BIT_ST_POLCHG] = 1'b1;
      end

      state_next.rdata = UNMAPPED_READ;
      if (rd_stb) begin
         unique case (addr)
            ADDR_CONTROL: state_next.rdata = {active, 1'b0, level, state_reg.invert,
                                              2'b00, state_reg.rise_en,
                                              state_reg.fall_en};
            ADDR_STATUS: state_next.rdata = {6'h00, state_reg.status};
            ADDR_MASK: state_next.rdata = {6'h00, state_reg.mask};
            ADDR_MODULE_DISABLE: state_next.rdata = {7'h00, state_reg.module_disable};
            default: state_next.rdata = UNMAPPED_READ;
         endcase
      end

      state_next.irq = |(state_next.status & state_next.mask);
      state_next.drive_en = active && state_reg.fuse_seen;
      state_next.level_out = level;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg.enable <= 1'b0;
         state_reg.invert <= CONTROL_RESET[BIT_INVERT];
         state_reg.rise_en <= CONTROL_RESET[BIT_RISE];
         state_reg.fall_en <= CONTROL_RESET[BIT_FALL];
         state_reg.module_disable <= 1'b0;
         state_reg.status <= STATUS_RESET;
         state_reg.mask <= MASK_RESET;
         state_reg.sync1 <= SYNC_RESET;
         state_reg.sync2 <= SYNC_RESET;
         state_reg.out_prev <= SYNC_RESET;
         state_reg.fuse_seen <= 1'b0;
         state_reg.rdata <= UNMAPPED_READ;
         state_reg.irq <= 1'b0;
         state_reg.drive_en <= 1'b0;
         state_reg.level_out <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign irq = state_reg.irq;
   assign detector_active = state_reg.drive_en;
   assign detector_logic_output = state_reg.level_out;

   // sleep is observed only so that nothing depends on it
   logic sleep_unused;
   assign sleep_unused = sleep_mode;

   AST_FUSE_CLEAR_ACTIVE: assert property (@(posedge clk) disable iff (!rstn)
      $past(state_reg.fuse_seen) && !$past(poweron_default_off_fuse) |-> detector_active)
      else $error("detector off with fuse clear");
   AST_FUSE_SET_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      poweron_default_off_fuse && !state_reg.enable |=> !detector_active)
      else $error("detector on without enable");
   AST_MODULE_DISABLE: assert property (@(posedge clk) disable iff (!rstn)
      poweron_default_off_fuse && state_reg.module_disable |=> !detector_active)
      else $error("module disable ignored");
   AST_RISE_SETS: assert property (@(posedge clk) disable iff (!rstn)
      active && state_reg.fuse_seen && state_reg.rise_en && level && !state_reg.out_prev
      |=> state_reg.status[BIT_ST_CROSS])
      else $error("rising edge lost");
   AST_FALL_SETS: assert property (@(posedge clk) disable iff (!rstn)
      active && state_reg.fuse_seen && state_reg.fall_en && !level && state_reg.out_prev
      |=> state_reg.status[BIT_ST_CROSS])
      else $error("falling edge lost");
   AST_NO_EDGE_KEEP: assert property (@(posedge clk) disable iff (!rstn)
      !state_reg.rise_en && !state_reg.fall_en && !state_reg.status[BIT_ST_CROSS]
      && !(wr_stb && addr == ADDR_STATUS) |=> !state_reg.status[BIT_ST_CROSS])
      else $error("flag set with edges disabled");
   AST_INVERT_EVENT: assert property (@(posedge clk) disable iff (!rstn)
      invert_changed |=> state_reg.status[BIT_ST_POLCHG])
      else $error("invert change gave no event");
   AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.status[BIT_ST_CROSS] && !(wr_stb && addr == ADDR_STATUS)
      |=> state_reg.status[BIT_ST_CROSS])
      else $error("flag cleared by hardware");
   AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_CONTROL |=> rdata[6] == 1'b0 && rdata[3:2] == 2'b00)
      else $error("unimplemented bits read nonzero");
   AST_SYNC_LATENCY: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.fuse_seen |-> ##2 (state_reg.sync2 == $past(sink_active, 2)))
      else $error("synchroniser latency wrong");


   // enable and pin ownership
   AST_DRIVE_LATE: assert property (@(posedge clk) disable iff (!rstn)
      !state_reg.fuse_seen |=> !detector_active)
      else $error("pin driven before fuse sampled");

   AST_DRIVE_OWN: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.fuse_seen && state_reg.enable && !state_reg.module_disable |=> detector_active)
      else $error("enabled detector not driving pin");

   AST_DRIVE_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
      detector_active |-> $past(active))
      else $error("pin held while detector off");

   AST_MD_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
      !poweron_default_off_fuse && state_reg.module_disable && state_reg.fuse_seen
      |=> detector_active)
      else $error("module disable acted with fuse clear");

   AST_ENABLE_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
      !poweron_default_off_fuse && !state_reg.enable && state_reg.fuse_seen |=> detector_active)
      else $error("enable bit acted with fuse clear");

   AST_MD_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      wr_stb && addr == ADDR_MODULE_DISABLE && wdata[BIT_MD_DISABLE] |=> state_reg.module_disable)
      else $error("module disable write lost");

   AST_MD_READ: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_MODULE_DISABLE |=> rdata[0] == $past(state_reg.module_disable))
      else $error("module disable read wrong");

   // logic level and polarity
   AST_LEVEL_READ: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_CONTROL |=> rdata[BIT_LEVEL] == $past(level))
      else $error("level bit read wrong");

   AST_INVERT_OUT: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.fuse_seen |-> detector_logic_output == $past(level))
      else $error("logic output not polarity adjusted");

   AST_INVERT_READ: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_CONTROL |=> rdata[BIT_INVERT] == $past(state_reg.invert))
      else $error("invert bit read wrong");

   AST_ENABLE_READ: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_CONTROL |=> rdata[BIT_ENABLE] == $past(active))
      else $error("enable bit read wrong");

   AST_INVERT_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      wr_ctl && wdata[BIT_INVERT] |=> state_reg.invert)
      else $error("invert write lost");

   AST_INVERT_WR_OFF: assert property (@(posedge clk) disable iff (!rstn)
      wr_ctl && !wdata[BIT_INVERT] |=> !state_reg.invert)
      else $error("invert clear lost");

   AST_INVERT_QUIET: assert property (@(posedge clk) disable iff (!rstn)
      !invert_changed |=> state_reg.invert == $past(state_reg.invert))
      else $error("invert moved without a write");

   // edge flagging
   AST_RISE_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
      !state_reg.rise_en && level && !state_reg.out_prev && !state_reg.status[BIT_ST_CROSS]
      |=> !state_reg.status[BIT_ST_CROSS])
      else $error("rising edge flagged while disabled");

   AST_FALL_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
      !state_reg.fall_en && !level && state_reg.out_prev && !state_reg.status[BIT_ST_CROSS]
      |=> !state_reg.status[BIT_ST_CROSS])
      else $error("falling edge flagged while disabled");

   AST_INACTIVE_NO_FLAG: assert property (@(posedge clk) disable iff (!rstn)
      !active && !state_reg.status[BIT_ST_CROSS] |=> !state_reg.status[BIT_ST_CROSS])
      else $error("edge flagged while detector off");

   AST_SLEEP_RISE: assert property (@(posedge clk) disable iff (!rstn)
      sleep_mode && rise_event |=> state_reg.status[BIT_ST_CROSS])
      else $error("rising edge lost in sleep");

   AST_SLEEP_FALL: assert property (@(posedge clk) disable iff (!rstn)
      sleep_mode && fall_event |=> state_reg.status[BIT_ST_CROSS])
      else $error("falling edge lost in sleep");

   AST_SYNC_FIRST: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.fuse_seen |=> state_reg.sync1 == $past(sink_active))
      else $error("first sync stage wrong");

   AST_SYNC_SECOND: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.fuse_seen |=> state_reg.sync2 == $past(state_reg.sync1))
      else $error("second sync stage wrong");

   // a slow analog edge must not flag twice
   AST_ONE_EVENT: assert property (@(posedge clk) disable iff (!rstn)
      rise_event |=> !rise_event)
      else $error("one transition gave two events");

   AST_CTRL_RISE_WR: assert property (@(posedge clk) disable iff (!rstn)
      wr_ctl && wdata[BIT_RISE] |=> state_reg.rise_en)
      else $error("rise enable write lost");

   AST_RISE_WR_OFF: assert property (@(posedge clk) disable iff (!rstn)
      wr_ctl && !wdata[BIT_RISE] |=> !state_reg.rise_en)
      else $error("rise enable clear lost");

   AST_FALL_WR_ON: assert property (@(posedge clk) disable iff (!rstn)
      wr_ctl && wdata[BIT_FALL] |=> state_reg.fall_en)
      else $error("fall enable write lost");

   AST_CTRL_FALL_WR: assert property (@(posedge clk) disable iff (!rstn)
      wr_ctl && !wdata[BIT_FALL] |=> !state_reg.fall_en)
      else $error("fall enable clear lost");

   // status and interrupt
   AST_SET_WINS: assert property (@(posedge clk) disable iff (!rstn)
      (rise_event || fall_event) && wr_stb && addr == ADDR_STATUS && wdata[BIT_ST_CROSS]
      |=> state_reg.status[BIT_ST_CROSS])
      else $error("edge lost against clear");

   AST_CLEAR_WORKS: assert property (@(posedge clk) disable iff (!rstn)
      wr_stb && addr == ADDR_STATUS && wdata[BIT_ST_CROSS] && !rise_event && !fall_event
      |=> !state_reg.status[BIT_ST_CROSS])
      else $error("flag clear ignored");

   AST_POLCHG_STICKY: assert property (@(posedge clk) disable iff (!rstn)
      state_reg.status[BIT_ST_POLCHG] && !(wr_stb && addr == ADDR_STATUS)
      |=> state_reg.status[BIT_ST_POLCHG])
      else $error("invert event dropped by hardware");

   AST_POLCHG_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
      wr_stb && addr == ADDR_STATUS && wdata[BIT_ST_POLCHG] |=> !state_reg.status[BIT_ST_POLCHG])
      else $error("invert event clear ignored");

   AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_STATUS |=> rdata[1:0] == $past(state_reg.status))
      else $error("status read wrong");

   AST_MASK_READ: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && addr == ADDR_MASK |=> rdata[1:0] == $past(state_reg.mask))
      else $error("mask read wrong");

   // irq is registered from the next state, so it tracks status and mask
   AST_IRQ_MATCH: assert property (@(posedge clk) disable iff (!rstn)
      irq == |(state_reg.status & state_reg.mask))
      else $error("irq disagrees with status and mask");

   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      !rd_stb |=> rdata == UNMAPPED_READ)
      else $error("read data outside read cycle");

   COV_SET_WINS: cover property (@(posedge clk) disable iff (!rstn)
      (rise_event || fall_event) && wr_stb && addr == ADDR_STATUS);
   COV_RISE: cover property (@(posedge clk) disable iff (!rstn)
      state_reg.rise_en && level && !state_reg.out_prev);
   COV_SET_CLEAR: cover property (@(posedge clk) disable iff (!rstn)
      wr_stb && addr == ADDR_STATUS && state_next.status[BIT_ST_CROSS]);
   COV_INVERT: cover property (@(posedge clk) disable iff (!rstn) invert_changed);
   COV_IRQ: cover property (@(posedge clk) disable iff (!rstn) irq);
endmodule : zcd_control

/* File: core/zcd_pkg.sv */
// constants and types shared by the zero-cross detector control block
package zcd_pkg;
   // register map, offsets are byte-independent word indices
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MASK = 4'h2;
   localparam logic [3:0] ADDR_MODULE_DISABLE = 4'h3;
   // control register field positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_LEVEL = 5;
   localparam int BIT_INVERT = 4;
   localparam int BIT_RISE = 1;
   localparam int BIT_FALL = 0;
   // status and module disable register field positions
   localparam int BIT_ST_CROSS = 0;
   localparam int BIT_ST_POLCHG = 1;
   localparam int BIT_MD_DISABLE = 0;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic SYNC_RESET = 1'b0;
   // what an unmapped read returns
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   typedef struct packed {
      logic enable;
      logic invert;
      logic rise_en;
      logic fall_en;
      logic module_disable;
      logic [1:0] status;
      logic [1:0] mask;
      logic sync1;
      logic sync2;
      logic out_prev;
      logic fuse_seen;
      logic [7:0] rdata;
      logic irq;
      logic drive_en;
      logic level_out;
   } zcd_state_type;
endpackage : zcd_pkg

/* File: bench/zcd_ac_source.sv */
// stand-in for the analog stage reporting source or sink
`timescale 1ns/1ps
module zcd_ac_source (
   // requested state
   input wire logic want_sink,
   // indication to the detector
   output logic sink_active
);
   initial sink_active = 1'b0;
   // lags off the clock grid so the synchroniser sees a true async edge
   always @(want_sink) sink_active <= #7 want_sink;
endmodule : zcd_ac_source

/* File: bench/test_zcd_control.sv */
// self-checking bench of the zero-cross detector control block
`timescale 1ns/1ps
module test_zcd_control;
   import zcd_pkg::*;
   logic clk = 0, rstn = 0, fuse = 0, sleep_mode = 0, wr_stb = 0, rd_stb = 0, want = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, d, r;
   logic sink_active, act, lvl, irq, en, inv, ri, fa, md;
   logic [1:0] st, mk;
   integer error_cnt = 0, compares = 0, seed = 63, cyc = 0, i;
   always #25 clk = ~clk;
   zcd_ac_source u_src (.want_sink(want), .sink_active(sink_active));
   zcd_control u_dut (.clk(clk), .rstn(rstn), .poweron_default_off_fuse(fuse),
      .sleep_mode(sleep_mode), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .sink_active(sink_active), .detector_active(act),
      .detector_logic_output(lvl), .irq(irq));
   task stop_test;
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task cmp(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk); addr <= a; wdata <= v; wr_stb <= 1'b1;
      @(posedge clk); wr_stb <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk); addr <= a; rd_stb <= 1'b1;
      @(posedge clk); rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd
   function logic eff();
      return fuse ? (en & ~md) : 1'b1;
   endfunction : eff
   // model edge flagging once the level has moved from o
   task upd(input logic o);
      if (eff() && (want ^ inv) != o && ((ri && (want ^ inv)) || (fa && !(want ^ inv))))
         st[0] = 1'b1;
   endtask : upd
   // ones written to reserved and read-only bits must be ignored
   task ctl(input logic e, input logic i2, input logic r2, input logic f2);
      if (i2 != inv) st[1] = 1'b1;
      en = e; inv = i2; ri = r2; fa = f2;
      wr(ADDR_CONTROL, {e, 2'b11, i2, 2'b11, r2, f2});
   endtask : ctl
   task tog;
      logic o;
      o = want ^ inv;
      @(posedge clk); want <= ~want;
      #1 upd(o);
   endtask : tog
   task check;
      repeat (6) @(posedge clk);
      rd(ADDR_CONTROL);
      cmp(d, {eff(), 1'b0, want ^ inv, inv, 2'b00, ri, fa});
      rd(ADDR_STATUS);
      cmp(d, {6'h00, st});
      cmp(act, eff());
      cmp(irq, |(st & mk));
      cmp(lvl, want ^ inv);
   endtask : check
   task do_reset(input logic f);
      @(posedge clk);
      rstn <= 1'b0; fuse <= f;
      en = 0; inv = 0; ri = 0; fa = 0; md = 0; st = 0; mk = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
   endtask : do_reset
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      do_reset(1'b0);
      check();
      wr(ADDR_MASK, 8'h03); mk = 2'h3;
      ctl(0, 0, 1, 0); tog(); check();
      tog(); check();
      wr(ADDR_STATUS, 8'h03); st = 2'h0; check();
      // clear lands in the cycle the rising edge sets the flag: set wins
      tog(); @(posedge clk); wr(ADDR_STATUS, 8'h01); check();
      do_reset(1'b1);
      check();
      wr(ADDR_MASK, 8'h03); mk = 2'h3;
      ctl(0, 1, 0, 0); check();
      ctl(1, 1, 1, 1); check();
      wr(ADDR_MODULE_DISABLE, 8'h01); md = 1; tog(); check();
      wr(ADDR_MODULE_DISABLE, 8'h00); md = 0; check();
      rd(4'hF); cmp(d, UNMAPPED_READ);
      sleep_mode <= 1'b1;
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         ctl(1, inv, r[0], r[1]);
         wr(ADDR_MASK, {6'h00, r[5:4]}); mk = r[5:4];
         if (r[2]) tog();
         check();
         if (r[3]) begin
            wr(ADDR_STATUS, {6'h00, r[7:6]}); st = st & ~r[7:6];
         end
      end
      check();
      stop_test();
   end
endmodule : test_zcd_control
